// >>> verilog/readout_regbank.sv
// Register bank of the readout chip: status, FIFO access, trigger snapshots, identifier.
// What this block does
// (RULE_01) A channel's data-valid outside a proper readout sequence sets its bit among 7..4.
// (RULE_02) A channel's almost-full arriving out of sequence sets its bit among 3..0.
// (RULE_03) The sequence error flags stay set until a resynchronise command or a reset.
// (RULE_04) The selector routes FIFO access: bit 5 trigger, bit 4 column, bits 3..0 channels D..A.
// (RULE_05) The 16-bit data port carries 12 data bits into the FIFO that the selector names.
// (RULE_06) A FIFO write happens only when the low byte of the data port is written.
// (RULE_07) Reading the data port returns the last FIFO entry and takes one word out of it.
// (RULE_08) The event count register shows the event counter captured at the last level-1 accept.
// (RULE_09) The bunch count register shows the bunch counter captured at the last level-1 accept.
// (RULE_10) A 1 in the trigger mask stops decoding of that command (3 BC0, 2 cal, 1 resync, 0 L1).
// (RULE_11) The last-command register shows a 1 in the bit of the last decoded command.
// (RULE_12) The identifier is a writable 16-bit word whose low byte is two address pins and 6 bits.
// (RULE_13) The identifier goes out with every event packet.
// (RULE_14) The latency register holds the wait in cycles before a calibration readout starts.
// (RULE_15) After a calibration command, a calibration event follows the latency unless suppressed.
// (RULE_16) FIFO access via the data port works only in test mode with transmission disabled.
// (RULE_17) A masked command leaves the last-command register unchanged.
`timescale 1ns/1ps
module readout_regbank (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] slave_addr_pins,
    input wire logic level_one_accept_cmd,
    input wire logic bunch_zero_cmd,
    input wire logic calibration_pulse_cmd,
    input wire logic resync_cmd,
    input wire logic [3:0] frontend_valid_err,
    input wire logic [3:0] almost_full_err,
    input wire logic [7:0] event_count,
    input wire logic [11:0] bunch_count,
    input wire logic [11:0] fifo_rd_data,
    output logic [5:0] fifo_sel_out,
    output logic fifo_wr,
    output logic fifo_rd,
    output logic [11:0] fifo_wr_data,
    output logic [15:0] packet_chip_id,
    output logic level_one_decoded,
    output logic bunch_zero_decoded,
    output logic calibration_decoded,
    output logic resync_decoded,
    output logic calibration_event_start,
    output logic test_mode,
    output logic tx_disable
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] config_reg;
        logic [7:0] cal_config;
        logic [7:0] fifo_selector;
        logic [7:0] data_high;
        logic [7:0] event_count_snapshot;
        logic [11:0] bunch_count_snapshot;
        logic [7:0] trigger_command_mask;
        logic [7:0] last_trigger_command;
        logic [7:0] chip_identifier_high;
        logic [5:0] chip_identifier_user;
        logic [7:0] latency;
        logic [7:0] cal_count;
        logic cal_pending;
        logic cal_start;
        logic fifo_wr;
        logic fifo_rd;
        logic [11:0] fifo_wr_data;
        logic [7:0] rdata;
        logic lv1_dec;
        logic bc0_dec;
        logic cal_dec;
        logic rsy_dec;
        logic [1:0] pins_meta;
        logic [1:0] pins_sync;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic [7:0] seq_flags;
    logic fifo_access_ok;
    logic [3:0] cmd_in;
    logic [3:0] cmd_pass;
    logic [7:0] chip_identifier_low;

    // ****************************************************************
    // Sticky sequence error flags
    // ****************************************************************
    seq_err_flags u_seq_err_flags (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .readout_err_evt(frontend_valid_err),
        .fifo_err_evt(almost_full_err),
        .resync_clear(cmd_pass[regbank_pkg::CMD_RESYNC_BIT]),
        .flags_r(seq_flags)
    );

    // Gather the incoming commands and pass only the unmasked ones.
    always_comb begin
        cmd_in = 4'h0;
        cmd_in[regbank_pkg::CMD_BUNCH_ZERO_BIT] = bunch_zero_cmd;
        cmd_in[regbank_pkg::CMD_CAL_PULSE_BIT] = calibration_pulse_cmd;
        cmd_in[regbank_pkg::CMD_RESYNC_BIT] = resync_cmd;
        cmd_in[regbank_pkg::CMD_LEVEL_ONE_BIT] = level_one_accept_cmd;
        cmd_pass = cmd_in & ~st_r.trigger_command_mask[3:0]; // RULE_10
    end

    // FIFO port is open only in test mode with the transmitter off.
    assign fifo_access_ok = st_r.config_reg[regbank_pkg::CFG_TEST_MODE_BIT] &
        st_r.config_reg[regbank_pkg::CFG_TX_DISABLE_BIT]; // RULE_16
    // Low identifier byte: two synchronised address pins above six user bits.
    assign chip_identifier_low = {st_r.pins_sync, st_r.chip_identifier_user}; // RULE_12

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.pins_meta = slave_addr_pins;
        st_nxt.pins_sync = st_r.pins_meta;
        st_nxt.fifo_wr = 1'b0;
        st_nxt.fifo_rd = 1'b0;
        st_nxt.cal_start = 1'b0;
        st_nxt.lv1_dec = cmd_pass[regbank_pkg::CMD_LEVEL_ONE_BIT]; // RULE_10
        st_nxt.bc0_dec = cmd_pass[regbank_pkg::CMD_BUNCH_ZERO_BIT];
        st_nxt.cal_dec = cmd_pass[regbank_pkg::CMD_CAL_PULSE_BIT];
        st_nxt.rsy_dec = cmd_pass[regbank_pkg::CMD_RESYNC_BIT];
        // Only a decoded command updates the indicator.
        if (cmd_pass != 4'h0) begin
            st_nxt.last_trigger_command = {4'h0, cmd_pass}; // RULE_11 RULE_17
        end
        // Snapshot counters at each decoded level-1 accept.
        if (cmd_pass[regbank_pkg::CMD_LEVEL_ONE_BIT]) begin
            st_nxt.event_count_snapshot = event_count; // RULE_08
            st_nxt.bunch_count_snapshot = bunch_count; // RULE_09
        end
        // Calibration latency countdown; a new command restarts it unless the suppress bit is set.
        if (st_r.cal_pending) begin
            if (st_r.cal_count == 8'h00) begin
                st_nxt.cal_pending = 1'b0;
                st_nxt.cal_start = 1'b1; // RULE_14 RULE_15
            end else begin
                st_nxt.cal_count = st_r.cal_count - 8'h01; // RULE_14
            end
        end
        if (cmd_pass[regbank_pkg::CMD_CAL_PULSE_BIT] &&
                !st_r.cal_config[regbank_pkg::CAL_SUPPRESS_BIT]) begin
            st_nxt.cal_pending = 1'b1; // RULE_15
            st_nxt.cal_count = st_r.latency;
        end
        // Register writes.
        if (reg_wr) begin
            unique case (reg_addr)
                regbank_pkg::IDX_CONFIG: st_nxt.config_reg = reg_wdata;
                regbank_pkg::IDX_CAL_CONFIG: st_nxt.cal_config = reg_wdata;
                regbank_pkg::IDX_FIFO_SEL: st_nxt.fifo_selector = {2'b00, reg_wdata[5:0]}; // RULE_04
                regbank_pkg::IDX_FIFO_DATA_H: st_nxt.data_high = reg_wdata;
                regbank_pkg::IDX_FIFO_DATA_L: begin
                    // Low-byte write commits the word, high byte taken from the holding register.
                    if (fifo_access_ok) begin // RULE_16
                        st_nxt.fifo_wr = 1'b1; // RULE_06
                        st_nxt.fifo_wr_data = {st_r.data_high[3:0], reg_wdata}; // RULE_05
                    end
                end
                regbank_pkg::IDX_TRIG_MASK: st_nxt.trigger_command_mask = {4'h0, reg_wdata[3:0]};
                regbank_pkg::IDX_CHIP_ID_L:
                    st_nxt.chip_identifier_user = reg_wdata[5:0]; // RULE_12
                regbank_pkg::IDX_CHIP_ID_H: st_nxt.chip_identifier_high = reg_wdata; // RULE_12
                regbank_pkg::IDX_LATENCY: st_nxt.latency = reg_wdata; // RULE_14
                default: begin
                end
            endcase
        end
        // Register reads; unmapped addresses return zero.
        if (reg_rd) begin
            unique case (reg_addr)
                regbank_pkg::IDX_CONFIG: st_nxt.rdata = st_r.config_reg;
                regbank_pkg::IDX_CAL_CONFIG: st_nxt.rdata = st_r.cal_config;
                regbank_pkg::IDX_SEQ_ERR: st_nxt.rdata = seq_flags; // RULE_01 RULE_02
                regbank_pkg::IDX_FIFO_SEL: st_nxt.rdata = st_r.fifo_selector;
                regbank_pkg::IDX_FIFO_DATA_L: begin
                    st_nxt.rdata = fifo_access_ok ? fifo_rd_data[7:0] : 8'h00; // RULE_07
                    st_nxt.fifo_rd = fifo_access_ok; // RULE_07 RULE_16
                end
                regbank_pkg::IDX_FIFO_DATA_H:
                    st_nxt.rdata = fifo_access_ok ? {4'h0, fifo_rd_data[11:8]} : 8'h00;
                regbank_pkg::IDX_EVENT_CNT: st_nxt.rdata = st_r.event_count_snapshot; // RULE_08
                regbank_pkg::IDX_BUNCH_CNT_L:
                    st_nxt.rdata = st_r.bunch_count_snapshot[7:0]; // RULE_09
                regbank_pkg::IDX_BUNCH_CNT_H:
                    st_nxt.rdata = {4'h0, st_r.bunch_count_snapshot[11:8]}; // RULE_09
                regbank_pkg::IDX_TRIG_MASK: st_nxt.rdata = st_r.trigger_command_mask;
                regbank_pkg::IDX_LAST_TRIG: st_nxt.rdata = st_r.last_trigger_command; // RULE_11
                regbank_pkg::IDX_CHIP_ID_L: st_nxt.rdata = chip_identifier_low;
                regbank_pkg::IDX_CHIP_ID_H: st_nxt.rdata = st_r.chip_identifier_high;
                regbank_pkg::IDX_LATENCY: st_nxt.rdata = st_r.latency;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.config_reg <= regbank_pkg::CONFIG_RESET;
            st_r.cal_config <= regbank_pkg::CAL_CONFIG_RESET;
            st_r.fifo_selector <= regbank_pkg::FIFO_SEL_RESET;
            st_r.trigger_command_mask <= regbank_pkg::TRIG_MASK_RESET;
            st_r.latency <= regbank_pkg::LATENCY_RESET;
            st_r.chip_identifier_high <= regbank_pkg::CHIP_ID_HIGH_RESET;
            st_r.chip_identifier_user <= regbank_pkg::CHIP_ID_USER_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs, all from flip-flops
    // ****************************************************************
    assign reg_rdata = st_r.rdata;
    assign fifo_sel_out = st_r.fifo_selector[5:0]; // RULE_04
    assign fifo_wr = st_r.fifo_wr;
    assign fifo_rd = st_r.fifo_rd;
    assign fifo_wr_data = st_r.fifo_wr_data;
    assign packet_chip_id = {st_r.chip_identifier_high, st_r.pins_sync,
        st_r.chip_identifier_user}; // RULE_13
    assign level_one_decoded = st_r.lv1_dec;
    assign bunch_zero_decoded = st_r.bc0_dec;
    assign calibration_decoded = st_r.cal_dec;
    assign resync_decoded = st_r.rsy_dec;
    assign calibration_event_start = st_r.cal_start;
    assign test_mode = st_r.config_reg[regbank_pkg::CFG_TEST_MODE_BIT];
    assign tx_disable = st_r.config_reg[regbank_pkg::CFG_TX_DISABLE_BIT];
endmodule // readout_regbank

// >>> verilog/regbank_pkg.sv
// Package of register indices, field positions and reset values for the readout register bank.
package regbank_pkg;
    // ****************************************************************
    // Register indices on the slow-control byte port
    // ****************************************************************
    localparam logic [4:0] IDX_CONFIG = 5'h00;
    localparam logic [4:0] IDX_CAL_CONFIG = 5'h01;
    localparam logic [4:0] IDX_SEQ_ERR = 5'h03;
    localparam logic [4:0] IDX_FIFO_SEL = 5'h04;
    localparam logic [4:0] IDX_FIFO_DATA_L = 5'h05;
    localparam logic [4:0] IDX_FIFO_DATA_H = 5'h06;
    localparam logic [4:0] IDX_EVENT_CNT = 5'h07;
    localparam logic [4:0] IDX_BUNCH_CNT_L = 5'h08;
    localparam logic [4:0] IDX_BUNCH_CNT_H = 5'h09;
    localparam logic [4:0] IDX_TRIG_MASK = 5'h0a;
    localparam logic [4:0] IDX_LAST_TRIG = 5'h0b;
    localparam logic [4:0] IDX_CHIP_ID_L = 5'h0c;
    localparam logic [4:0] IDX_CHIP_ID_H = 5'h0d;
    localparam logic [4:0] IDX_LATENCY = 5'h0e;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CFG_TEST_MODE_BIT = 7;
    localparam int CFG_TX_DISABLE_BIT = 5;
    localparam int CAL_SUPPRESS_BIT = 1;
    localparam int SEQ_READOUT_LSB = 4;
    localparam int SEQ_FIFO_LSB = 0;
    localparam int CMD_BUNCH_ZERO_BIT = 3;
    localparam int CMD_CAL_PULSE_BIT = 2;
    localparam int CMD_RESYNC_BIT = 1;
    localparam int CMD_LEVEL_ONE_BIT = 0;
    localparam int SEL_TRIGGER_FIFO_BIT = 5;
    localparam int SEL_COLUMN_FIFO_BIT = 4;
    localparam int NUM_CHANNELS = 4;
    localparam int FIFO_DATA_WIDTH = 12;
    localparam int CHIP_ID_USER_BITS = 6;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CAL_CONFIG_RESET = 8'h00;
    localparam logic [7:0] FIFO_SEL_RESET = 8'h00;
    localparam logic [7:0] TRIG_MASK_RESET = 8'h00;
    localparam logic [7:0] LATENCY_RESET = 8'h00;
    // Upper identifier byte after reset; the value is arbitrary.
    localparam logic [7:0] CHIP_ID_HIGH_RESET = 8'h00;
    localparam logic [5:0] CHIP_ID_USER_RESET = 6'h00;
endpackage

// >>> verilog/seq_err_flags.sv
// Sticky per-channel sequence error flags with a resynchronise clear.
`timescale 1ns/1ps
module seq_err_flags (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] readout_err_evt,
    input wire logic [3:0] fifo_err_evt,
    input wire logic resync_clear,
    output logic [7:0] flags_r
);
    logic [7:0] flags_nxt;

    // ****************************************************************
    // Flag update
    // ****************************************************************
    // Each bit holds once set; an event on the clearing cycle still wins.
    genvar ch;
    generate
        for (ch = 0; ch < regbank_pkg::NUM_CHANNELS; ch = ch + 1) begin : g_ch
            always_comb begin
                flags_nxt[regbank_pkg::SEQ_READOUT_LSB + ch] = readout_err_evt[ch] |
                    (flags_r[regbank_pkg::SEQ_READOUT_LSB + ch] & ~resync_clear); // RULE_01 RULE_03
                flags_nxt[regbank_pkg::SEQ_FIFO_LSB + ch] = fifo_err_evt[ch] |
                    (flags_r[regbank_pkg::SEQ_FIFO_LSB + ch] & ~resync_clear); // RULE_02 RULE_03
            end
        end
    endgenerate

    // Flags clear on reset.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= 8'h00; // RULE_03
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule // seq_err_flags

// >>> test/readout_regbank_chk.sv
// Port checker of the readout register bank, bound to the top module.
`timescale 1ns/1ps
module readout_regbank_chk (
    input wire logic sys_clk, rst_n, reg_wr, reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic [1:0] slave_addr_pins,
    input wire logic level_one_accept_cmd, bunch_zero_cmd, calibration_pulse_cmd, resync_cmd,
    input wire logic [11:0] fifo_rd_data, fifo_wr_data,
    input wire logic [5:0] fifo_sel_out,
    input wire logic [15:0] packet_chip_id,
    input wire logic fifo_wr, fifo_rd, test_mode, tx_disable,
    input wire logic level_one_decoded, bunch_zero_decoded, calibration_decoded, resync_decoded
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Qualified accesses to the low byte of the data port.
    wire port_open = test_mode && tx_disable;
    wire wr_low = reg_wr && reg_addr == regbank_pkg::IDX_FIFO_DATA_L;
    wire rd_low = reg_rd && reg_addr == regbank_pkg::IDX_FIFO_DATA_L;
    AST_FIFO_WR_COMMIT: assert property (wr_low && port_open |=>
        fifo_wr && fifo_wr_data[7:0] == $past(reg_wdata)) else $error("Word not committed.");
    AST_FIFO_WR_ONLY_LOW: assert property (fifo_wr |-> $past(wr_low && port_open))
        else $error("FIFO write without a low byte write.");
    AST_FIFO_RD_POP: assert property (rd_low && port_open |=>
        fifo_rd && reg_rdata == $past(fifo_rd_data[7:0])) else $error("Read did not pop.");
    AST_FIFO_GATE: assert property (fifo_rd |-> $past(rd_low && port_open))
        else $error("FIFO pop outside test mode.");
    AST_CONFIG_BITS: assert property (reg_wr && reg_addr == regbank_pkg::IDX_CONFIG |=>
        test_mode == $past(reg_wdata[7]) && tx_disable == $past(reg_wdata[5]))
        else $error("Config bits not taken.");
    AST_SELECTOR: assert property (reg_wr && reg_addr == regbank_pkg::IDX_FIFO_SEL |=>
        fifo_sel_out == $past(reg_wdata[5:0])) else $error("Selector not taken.");
    AST_DECODE_L1_RESYNC: assert property ((level_one_decoded |-> $past(level_one_accept_cmd))
        and (resync_decoded |-> $past(resync_cmd))) else $error("Decode without command.");
    AST_DECODE_BUNCH_CAL: assert property ((bunch_zero_decoded |-> $past(bunch_zero_cmd))
        and (calibration_decoded |-> $past(calibration_pulse_cmd)))
        else $error("Decode without command.");
    AST_ID_HIGH: assert property (reg_wr && reg_addr == regbank_pkg::IDX_CHIP_ID_H |->
        ##[1:2] packet_chip_id[15:8] == $past(reg_wdata)) else $error("Id high not sent.");
    AST_ID_LOW: assert property (reg_wr && reg_addr == regbank_pkg::IDX_CHIP_ID_L |->
        ##[1:2] packet_chip_id[5:0] == $past(reg_wdata[5:0])) else $error("Id low not sent.");
    AST_ID_PINS: assert property ($stable(slave_addr_pins) [*4] |->
        packet_chip_id[7:6] == slave_addr_pins) else $error("Id pins not shown.");
endmodule // readout_regbank_chk
bind readout_regbank readout_regbank_chk chk (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .slave_addr_pins, .level_one_accept_cmd, .bunch_zero_cmd,
    .calibration_pulse_cmd, .resync_cmd, .fifo_rd_data, .fifo_wr_data, .fifo_sel_out,
    .packet_chip_id, .fifo_wr, .fifo_rd, .test_mode, .tx_disable, .level_one_decoded,
    .bunch_zero_decoded, .calibration_decoded, .resync_decoded);

// >>> test/reg_host.sv
// Slow-control master model driving the byte register port.
`timescale 1ns/1ps
module reg_host (
    input wire logic sys_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [4:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
    end
    // One byte write; the data is scrambled once the strobe is gone.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    // One byte read; the answer is taken after the sampling edge.
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // reg_host

// >>> test/readout_regbank_tb.sv
// Self-checking bench of the readout register bank.
`timescale 1ns/1ps
module readout_regbank_tb;
    typedef struct packed {logic [4:0] a; logic [7:0] w; logic [7:0] e;} row_type;
    // Each row writes a value and then expects the read-back value.
    row_type rows [12] = '{
        '{5'h04, 8'hff, 8'h3f}, '{5'h0a, 8'hff, 8'h0f}, '{5'h0a, 8'h00, 8'h00},
        '{5'h0e, 8'h5a, 8'h5a}, '{5'h0d, 8'ha5, 8'ha5}, '{5'h0c, 8'hff, 8'hbf},
        '{5'h0b, 8'hff, 8'h00}, '{5'h03, 8'hff, 8'h00}, '{5'h07, 8'hff, 8'h00},
        '{5'h1f, 8'hff, 8'h00}, '{5'h01, 8'h02, 8'h02}, '{5'h00, 8'ha0, 8'ha0}};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] cmd_v = 4'h0;
    logic [3:0] fv_err = 4'h0;
    logic [3:0] af_err = 4'h0;
    logic [7:0] event_count = 8'h00;
    logic [11:0] bunch_count = 12'h000;
    logic [11:0] fifo_rd_data = 12'h000;
    logic [1:0] pins = 2'b10;
    logic reg_wr, reg_rd, fifo_wr, fifo_rd, test_mode, tx_disable, cal_start;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [5:0] fifo_sel_out;
    logic [11:0] fifo_wr_data, wr_seen;
    logic [15:0] packet_chip_id;
    logic [15:0] wr_cnt = 16'h0000;
    logic [15:0] rd_cnt = 16'h0000;
    logic [3:0] dec;
    int fails = 0;
    int cmp_count = 0;
    int n, k;
    reg_host host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    readout_regbank dut (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .slave_addr_pins(pins), .level_one_accept_cmd(cmd_v[0]), .resync_cmd(cmd_v[1]),
        .calibration_pulse_cmd(cmd_v[2]), .bunch_zero_cmd(cmd_v[3]), .frontend_valid_err(fv_err),
        .almost_full_err(af_err), .event_count, .bunch_count, .fifo_rd_data, .fifo_sel_out,
        .fifo_wr, .fifo_rd, .fifo_wr_data, .packet_chip_id, .level_one_decoded(dec[0]),
        .resync_decoded(dec[1]), .calibration_decoded(dec[2]), .bunch_zero_decoded(dec[3]),
        .calibration_event_start(cal_start), .test_mode, .tx_disable);
    initial forever #4 sys_clk = ~sys_clk;
    // Counts FIFO strobes at the falling edge, where they are settled.
    always @(negedge sys_clk) begin
        if (fifo_wr === 1'b1) begin
            wr_cnt++;
            wr_seen = fifo_wr_data;
        end
        if (fifo_rd === 1'b1)
            rd_cnt++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        @(negedge sys_clk);
        #1;
    endtask
    // Pulses one command for one cycle and checks the decoded pulses.
    task automatic pulse(input int i, input logic [3:0] exp);
        @(posedge sys_clk);
        cmd_v <= 4'h1 << i;
        @(posedge sys_clk);
        cmd_v <= 4'h0;
        #1;
        check(16'(dec), 16'(exp));
    endtask
    task automatic wait_cal(output int cnt);
        for (cnt = 1; cnt <= 20; cnt++) begin
            @(posedge sys_clk);
            #1;
            if (cal_start === 1'b1)
                break;
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].w);
            host.rd(rows[i].a, d);
            check(16'(d), 16'(rows[i].e));
        end
        check(packet_chip_id, 16'ha5bf);
        // A reset in mid-run clears every register.
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(16'({fifo_sel_out, test_mode, tx_disable}), 16'h0000);
        rst_n <= 1'b1;
        for (k = 0; k < 16; k++) begin
            host.rd(5'(k), d);
            check(16'(d), (k == 12) ? 16'h0080 : 16'h0000);
        end
        // Each command is decoded alone; the next one, masked, must leave the indicator as is.
        for (k = 0; k < 4; k++) begin
            pulse(k, 4'h1 << k);
            host.rd(5'h0b, d);
            check(16'(d), 16'h1 << k);
            host.wr(5'h0a, 8'h0f);
            pulse((k + 1) % 4, 4'h0);
            host.rd(5'h0b, d);
            check(16'(d), 16'h1 << k);
            host.wr(5'h0a, 8'h00);
        end
        @(posedge sys_clk);
        fv_err <= 4'ha;
        af_err <= 4'h1;
        @(posedge sys_clk);
        fv_err <= 4'h0;
        af_err <= 4'h0;
        host.rd(5'h03, d);
        check(16'(d), 16'h00a1);
        host.wr(5'h0a, 8'h02);
        pulse(1, 4'h0);
        host.rd(5'h03, d);
        check(16'(d), 16'h00a1);
        host.wr(5'h0a, 8'h00);
        pulse(1, 4'h2);
        host.rd(5'h03, d);
        check(16'(d), 16'h0000);
        // An error on the resynchronise cycle still sets its flag.
        @(posedge sys_clk);
        fv_err <= 4'h1;
        cmd_v <= 4'h2;
        @(posedge sys_clk);
        fv_err <= 4'h0;
        cmd_v <= 4'h0;
        host.rd(5'h03, d);
        check(16'(d), 16'h0010);
        // Counter snapshots at a level-1 accept, and none when masked.
        @(posedge sys_clk);
        event_count <= 8'h3c;
        bunch_count <= 12'h5e7;
        pulse(0, 4'h1);
        @(posedge sys_clk);
        event_count <= 8'h11;
        bunch_count <= 12'h222;
        host.wr(5'h0a, 8'h01);
        pulse(0, 4'h0);
        host.rd(5'h07, d);
        check(16'(d), 16'h003c);
        host.rd(5'h08, d);
        check(16'(d), 16'h00e7);
        host.rd(5'h09, d);
        check(16'(d), 16'h0005);
        host.wr(5'h0a, 8'h00);
        // Calibration event after the latency, then suppressed.
        host.wr(5'h0e, 8'h05);
        pulse(2, 4'h4);
        wait_cal(n);
        check(16'(n), 16'h0006);
        if (n > 20)
            close_out();
        host.wr(5'h01, 8'h02);
        pulse(2, 4'h4);
        wait_cal(n);
        check(16'(n), 16'h0015);
        // FIFO access through the data port in test mode.
        host.wr(5'h00, 8'haf);
        check(16'({test_mode, tx_disable}), 16'h0003);
        for (k = 0; k < 6; k++) begin
            host.wr(5'h04, 8'h1 << k);
            check(16'(fifo_sel_out), 16'h1 << k);
        end
        host.wr(5'h04, 8'h04);
        host.wr(5'h06, 8'h0b);
        settle();
        check(wr_cnt, 16'h0000);
        host.wr(5'h05, 8'hcd);
        settle();
        check(wr_cnt, 16'h0001);
        check(16'(wr_seen), 16'h0bcd);
        @(posedge sys_clk);
        fifo_rd_data <= 12'h9e1;
        host.rd(5'h06, d);
        check(16'(d), 16'h0009);
        host.rd(5'h05, d);
        settle();
        check(16'(d), 16'h00e1);
        check(rd_cnt, 16'h0001);
        // Transmission enabled: the data port refuses access.
        host.wr(5'h00, 8'h80);
        host.wr(5'h05, 8'h12);
        host.rd(5'h05, d);
        settle();
        check(16'(d), 16'h0000);
        check(wr_cnt + rd_cnt, 16'h0002);
        close_out();
    end
endmodule // readout_regbank_tb
